// ### hw/crvs_addr_mux.v
/*
  address selector: forms the bus address for each start cycle.
  assumes the cycle code and register values come from the sequencer.
*/
`include "crvs_defs.vh"
module crvs_addr_mux (
  input  wire [2:0]  cycle_in,
  input  wire [15:0] last_addr_in,
  input  wire [7:0]  stack_pointer_in,
  input  wire [15:0] program_counter_in,
  output reg  [15:0] addr_out
);
  // stack cycles always live in page one
  always @* begin
    case (cycle_in)
      `CRVS_CYC_HOLD:   addr_out = last_addr_in;
      `CRVS_CYC_DUMMY1: addr_out = last_addr_in + 16'h0001;
      `CRVS_CYC_STACK0: addr_out = {`CRVS_STACK_PAGE, stack_pointer_in};
      `CRVS_CYC_STACK1: addr_out = {`CRVS_STACK_PAGE, stack_pointer_in - 8'h01};
      `CRVS_CYC_STACK2: addr_out = {`CRVS_STACK_PAGE, stack_pointer_in - 8'h02};
      `CRVS_CYC_VEC_LO: addr_out = `CRVS_RST_VEC_LO;
      `CRVS_CYC_VEC_HI: addr_out = `CRVS_RST_VEC_HI;
      default:          addr_out = program_counter_in;
    endcase
  end
endmodule

// ### hw/crvs_defs.vh
/*
  constants for the reset and start-up sequencer: vector addresses,
  stack page base and sequence cycle codes.
  assumes inclusion by bare name from the design files.
*/
`ifndef CRVS_DEFS_VH
`define CRVS_DEFS_VH
`define CRVS_NMI_VEC_LO    16'hfffa
`define CRVS_NMI_VEC_HI    16'hfffb
`define CRVS_RST_VEC_LO    16'hfffc
`define CRVS_RST_VEC_HI    16'hfffd
`define CRVS_IRQ_VEC_LO    16'hfffe
`define CRVS_IRQ_VEC_HI    16'hffff
`define CRVS_STACK_PAGE    8'h01
`define CRVS_ADDR_RESET    16'h0000
`define CRVS_SP_RESET      8'h00
`define CRVS_PC_RESET      16'h0000
`define CRVS_CYC_W         3
`define CRVS_CYC_HOLD      3'h0
`define CRVS_CYC_DUMMY1    3'h1
`define CRVS_CYC_STACK0    3'h2
`define CRVS_CYC_STACK1    3'h3
`define CRVS_CYC_STACK2    3'h4
`define CRVS_CYC_VEC_LO    3'h5
`define CRVS_CYC_VEC_HI    3'h6
`define CRVS_CYC_RUN       3'h7
`endif

// ### hw/crvs_sequencer.v
/*
  reset and start-up sequencer of an 8-bit processor core.
  holds the bus in read during reset, runs the seven-cycle start
  sequence, loads the program counter from the reset vector and then
  hands the bus to normal execution. assumes memory answers reads in
  the same cycle and an external source drives the common reset line.
*/
// Notes on behaviour
// - top six bytes hold nmi, reset, irq vectors in ascending order.
// - each vector is a low then high program counter byte loaded by hardware.
// - while reset is low, stay stopped and issue only reads.
// - read/write stays read until both reset vector bytes are addressed.
// - sequence works from any register contents; nothing else needs defining.
// - start one cycle after release; dummy address then address plus one.
// - cycles three to five address page one plus sp, sp-1, sp-2.
// - no writes during the three stack cycles.
// - cycle six reads vector low byte, cycle seven reads high byte.
// - seven cycles, then first opcode fetched from the vector address.
// - interrupt disable flag is set during the start sequence.
// - only interrupt disable and program counter are initialised.
// - interrupt disable never blocks the non-maskable request.
// - reset source holds line low at power-up; start on rising edge.
// - stack addresses are page one base plus the stack pointer.
`include "crvs_defs.vh"
module crvs_sequencer (
  input  wire        core_clk_in,
  input  wire        rstn_in,
  input  wire [7:0]  data_in,
  input  wire        core_write_in,
  input  wire [15:0] core_addr_in,
  input  wire        irq_request_in,
  input  wire        nmi_request_in,
  input  wire        irq_disable_clear_in,
  input  wire [7:0]  stack_pointer_in,
  output reg  [15:0] addr_out,
  output wire        read_not_write_out,
  output reg  [15:0] program_counter_out,
  output reg         irq_disable_out,
  output reg         start_done_out,
  output reg         first_fetch_out,
  output wire        irq_accept_out,
  output reg         nmi_pending_out,
  output wire        reset_hold_out
);
  reg  [2:0]  cycle;
  reg  [2:0]  next_cycle;
  reg         rst_sync;
  reg         rst_seen;
  reg  [15:0] last_addr;
  reg  [7:0]  vec_low;
  reg  [15:0] next_program_counter;
  reg         nmi_prev;
  wire [15:0] seq_addr;

  // reset line sampled on the core clock, so release acts on a clean edge
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync <= 1'b0;
      rst_seen <= 1'b0;
    end else begin
      rst_sync <= 1'b1;
      rst_seen <= rst_sync;
    end
  end

  assign reset_hold_out = ~rst_seen;

  // cycle counter: hold, then one step per clock until run
  always @* begin
    next_cycle = cycle;
    if (!rst_seen) begin
      next_cycle = `CRVS_CYC_HOLD;
    end else if (cycle != `CRVS_CYC_RUN) begin
      next_cycle = cycle + 3'h1;
    end
  end

  // hold state counts as start cycle one: first address after release
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cycle <= `CRVS_CYC_HOLD;
    end else begin
      cycle <= next_cycle;
    end
  end

  crvs_addr_mux u_addr_mux (
    .cycle_in           (cycle),
    .last_addr_in       (last_addr),
    .stack_pointer_in   (stack_pointer_in),
    .program_counter_in (next_program_counter),
    .addr_out           (seq_addr)
  );

  // bus address register; after start the core owns the address
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_out  <= `CRVS_ADDR_RESET;
      last_addr <= `CRVS_ADDR_RESET;
    end else if (cycle == `CRVS_CYC_RUN && start_done_out) begin
      addr_out  <= core_addr_in;
      last_addr <= core_addr_in;
    end else begin
      addr_out  <= seq_addr;
      if (cycle == `CRVS_CYC_HOLD) begin
        last_addr <= last_addr; // dummy address is last_addr, which reset has cleared to CRVS_ADDR_RESET
      end else begin
        last_addr <= seq_addr;
      end
    end
  end

  // writes only ever pass once start is done; reset forces read at once
  assign read_not_write_out = ~(start_done_out & rst_seen & core_write_in);

  // vector bytes captured as they arrive, then form the program counter;
  // addr_out lags the cycle code by one edge, so the high byte is on the
  // bus during the first run cycle and the fetch address goes out next
  always @* begin
    next_program_counter = program_counter_out;
    if (cycle == `CRVS_CYC_RUN && !start_done_out) begin
      next_program_counter = {data_in, vec_low};
    end
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vec_low             <= 8'h00;
      program_counter_out <= `CRVS_PC_RESET;
    end else begin
      if (cycle == `CRVS_CYC_VEC_HI) begin
        vec_low <= data_in;
      end
      program_counter_out <= next_program_counter;
    end
  end

  // start done and the first fetch strobe on cycle eight
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      start_done_out  <= 1'b0;
      first_fetch_out <= 1'b0;
    end else begin
      start_done_out  <= (cycle == `CRVS_CYC_RUN) & rst_seen;
      first_fetch_out <= (cycle == `CRVS_CYC_RUN) && !start_done_out && rst_seen;
    end
  end

  // interrupt disable: set by the start sequence, cleared only by software
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_disable_out <= 1'b1;
    end else if (!start_done_out) begin
      irq_disable_out <= 1'b1;
    end else if (irq_disable_clear_in) begin
      irq_disable_out <= 1'b0;
    end
  end

  assign irq_accept_out = irq_request_in & ~irq_disable_out & start_done_out;

  // nmi edges are latched regardless of the disable flag, served after start
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nmi_prev        <= 1'b0;
      nmi_pending_out <= 1'b0;
    end else begin
      nmi_prev <= nmi_request_in;
      if (nmi_request_in & ~nmi_prev) begin
        nmi_pending_out <= 1'b1;
      end else if (start_done_out) begin
        nmi_pending_out <= 1'b0; // handed to the core once running
      end
    end
  end

  // nmi/reset/irq vectors fixed at the top six bytes, see header
  wire [15:0] vec_nmi_lo = `CRVS_NMI_VEC_LO;
endmodule

// ### verification/crvs_mem_model.sv
/*
  memory model on the far side of the sequencer bus.
  assumes reads are answered in the same cycle as the address.
*/
module crvs_mem_model (
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] vec_in,
  output logic      [7:0]  data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // fixed nmi vector bytes, reset vector bytes from vec_in; elsewhere a moving pattern, never a stale byte
  always_comb begin
    case (addr_in)
      16'hfffa, 16'hfffb: data_out = 8'h5a;
      16'hfffc: data_out = vec_in[7:0];
      16'hfffd: data_out = vec_in[15:8];
      default: data_out = ~addr_in[7:0];
    endcase
  end
endmodule

// ### verification/crvs_seq_monitor.sv
/*
  checker on the sequencer ports.
  assumes it is bound into crvs_sequencer.
*/
module crvs_seq_monitor (
  input wire        core_clk_in,
  input wire        rstn_in,
  input wire [7:0]  data_in,
  input wire [7:0]  stack_pointer_in,
  input wire        nmi_request_in,
  input wire [15:0] addr_out,
  input wire        read_not_write_out,
  input wire        irq_disable_out,
  input wire        start_done_out,
  input wire        first_fetch_out,
  input wire        irq_accept_out,
  input wire        nmi_pending_out,
  input wire        reset_hold_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // reads only, also while reset is low
  a_read_in_reset: assert property (disable iff (1'b0) !rstn_in |-> read_not_write_out)
    else $error("write during reset");
  a_hold_reads: assert property (reset_hold_out |-> read_not_write_out)
    else $error("write during hold");
  a_no_early_write: assert property (!start_done_out |-> read_not_write_out)
    else $error("write before start done");
  a_stack_walk: assert property (!start_done_out && addr_out == 16'hfffc |->
    $past(addr_out, 3) == {8'h01, stack_pointer_in}
    && $past(addr_out, 2) == {8'h01, stack_pointer_in - 8'h01}
    && $past(addr_out, 1) == {8'h01, stack_pointer_in - 8'h02})
    else $error("stack address walk wrong");
  a_fetch_vector: assert property (first_fetch_out |-> $past(addr_out) == 16'hfffd
    && $past(addr_out, 2) == 16'hfffc && addr_out == {$past(data_in), $past(data_in, 2)})
    else $error("first fetch not from vector");
  a_fetch_once: assert property (first_fetch_out |=> !first_fetch_out && start_done_out)
    else $error("first fetch not a pulse");
  a_irq_masked: assert property (irq_disable_out |-> !irq_accept_out)
    else $error("irq taken while disabled");
  a_disable_start: assert property (!start_done_out |-> irq_disable_out)
    else $error("disable clear during start");
  a_nmi_kept: assert property ($rose(nmi_request_in) ##1 !start_done_out |-> nmi_pending_out)
    else $error("nmi lost during start");
  c_fetch: cover property (first_fetch_out);
  c_nmi: cover property (nmi_pending_out);
  c_write: cover property (!read_not_write_out);
endmodule
bind crvs_sequencer crvs_seq_monitor u_mon (.core_clk_in, .rstn_in, .data_in,
  .stack_pointer_in, .nmi_request_in, .addr_out, .read_not_write_out, .irq_disable_out,
  .start_done_out, .first_fetch_out, .irq_accept_out, .nmi_pending_out, .reset_hold_out);

// ### verification/crvs_sequencer_bench.sv
/*
  self-checking bench of the start sequencer with a memory model.
  assumes the monitor is bound in and the clock runs at 250 MHz.
*/
module crvs_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 0, rstn_in = 0, core_write_in = 0, irq_request_in = 0;
  logic nmi_request_in = 0, irq_disable_clear_in = 0;
  logic [15:0] core_addr_in = 16'h0000, vec = 16'h0000;
  logic [7:0]  stack_pointer_in = 8'h00;
  wire  [7:0]  data_in;
  wire  [15:0] addr_out, program_counter_out;
  wire  read_not_write_out, irq_disable_out, start_done_out, first_fetch_out;
  wire  irq_accept_out, nmi_pending_out, reset_hold_out;
  int   bad_count = 0, compares = 0;
  crvs_sequencer dut (.core_clk_in, .rstn_in, .data_in, .core_write_in, .core_addr_in,
    .irq_request_in, .nmi_request_in, .irq_disable_clear_in, .stack_pointer_in, .addr_out,
    .read_not_write_out, .program_counter_out, .irq_disable_out, .start_done_out,
    .first_fetch_out, .irq_accept_out, .nmi_pending_out, .reset_hold_out);
  crvs_mem_model mem (.addr_in(addr_out), .vec_in(vec), .data_out(data_in));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // reset, release, then follow the address trail up to the first fetch
  task t_start(input logic [7:0] sp, input logic [15:0] v);
    logic [15:0] h [0:7];
    @(posedge core_clk_in);
    stack_pointer_in <= sp;
    vec <= v;
    rstn_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(read_not_write_out, 1);
    @(posedge core_clk_in);
    rstn_in <= 1'b1;
    for (int n = 0; n < 30; n++) begin
      @(posedge core_clk_in);
      #1;
      for (int k = 7; k > 0; k--) h[k] = h[k-1];
      h[0] = addr_out;
      if (first_fetch_out === 1'b1) break;
    end
    chk(first_fetch_out, 1);
    chk(h[0], v);
    chk(program_counter_out, v);
    chk(h[1], 16'hfffd);
    chk(h[2], 16'hfffc);
    chk(h[3], {8'h01, sp - 8'h02});
    chk(h[4], {8'h01, sp - 8'h01});
    chk(h[5], {8'h01, sp});
    chk(h[6], h[7] + 16'h0001);
    chk(irq_disable_out, 1);
  endtask
  // core writes once running, then reset cuts in mid-write
  task t_run;
    @(posedge core_clk_in);
    core_addr_in <= 16'h0234;
    core_write_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(read_not_write_out, 0);
    chk(addr_out, 16'h0234);
    @(posedge core_clk_in);
    rstn_in <= 1'b0;
    #1;
    chk(read_not_write_out, 1);
    chk(reset_hold_out, 1);
  endtask
  // requests and an early clear during start; clear only lands afterwards
  task t_int;
    @(posedge core_clk_in);
    irq_request_in <= 1'b1;
    irq_disable_clear_in <= 1'b1;
    rstn_in <= 1'b0;
    @(posedge core_clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    nmi_request_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(nmi_pending_out, 1);
    chk(irq_accept_out, 0);
    repeat (20) @(posedge core_clk_in);
    #1;
    chk(start_done_out, 1);
    chk(irq_accept_out, 1);
    chk(nmi_pending_out, 0);
  endtask
  initial begin
    forever #2 core_clk_in = ~core_clk_in;
  end
  // whole run is about sixty cycles
  initial begin
    #4000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge core_clk_in);
    t_start(8'h01, 16'hc3a5);
    t_run;
    t_start(8'h80, 16'h8e10);
    t_int;
    test_done;
  end
endmodule
